// ### src/rshpc_pkg.sv
// Package of constants and types for the reset, strap and host pin configuration block.
`default_nettype none
package rshpc_pkg;
  // Clock period in nanoseconds.
  localparam int unsigned CLK_PERIOD_NS = 20;
  // Least reset pulse width in milliseconds.
  localparam int unsigned RST_MIN_MS = 2;
  // Wait after reset release before register access, in milliseconds.
  localparam int unsigned READY_WAIT_MS = 50;
  // Cycle counts derived from the times above (least times round up).
  localparam int unsigned RST_MIN_CYC = (RST_MIN_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned READY_WAIT_CYC =
    (READY_WAIT_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Number of general purpose pins.
  localparam int unsigned GPIO_W = 12;
  // Internal pull levels of the general purpose pins: 5:0 low, 11:6 high.
  localparam logic [11:0] GPIO_PULL = 12'hFC0;
  // Strap pin positions.
  localparam int unsigned PROTO_BIT = 3;
  localparam int unsigned RATE_LO_BIT = 0;
  localparam int unsigned RATE_HI_BIT = 1;
  // Ready flag position within the status word at address 0x00.
  localparam int unsigned READY_BIT = 7;
  localparam logic [7:0] STATUS_ADDR = 8'h00;
  // Number of configurable outputs and pairs.
  localparam int unsigned OUT_N = 8;
  localparam int unsigned PAIR_N = 4;
  // Width of a clock source select code.
  localparam int unsigned SEL_W = 2;
  // Number of stages of the pin synchroniser.
  localparam int unsigned SYNC_W = 3;
  // Sequencer states, Gray coded along the usual path.
  typedef enum logic [1:0]
  {
    RSHPC_RESET = 2'b00,
    RSHPC_WAIT  = 2'b01,
    RSHPC_READY = 2'b11
  } rshpc_state_t;
  // Host protocol selected by the strap.
  typedef enum logic
  {
    RSHPC_I2C = 1'b0,
    RSHPC_SPI = 1'b1
  } rshpc_proto_t;
endpackage : rshpc_pkg
`default_nettype wire

// ### src/rshpc_sync_if.sv
// Interface carrying a pin group to and from the synchroniser module.
`default_nettype none
interface rshpc_sync_if #(parameter int unsigned W = 1);
  // Raw asynchronous levels.
  logic [W-1:0] raw;
  // Filtered levels, changed once two stages agree.
  logic [W-1:0] clean;
  // Side that drives raw pins and reads the result.
  modport user (output raw, input clean);
  // Synchroniser side.
  modport sync (input raw, output clean);
endinterface : rshpc_sync_if
`default_nettype wire

// ### src/rshpc_sync.sv
// Three stage pin synchroniser that accepts a change once stages two and three agree.
`default_nettype none
module rshpc_sync
  import rshpc_pkg::*;
#(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] INIT = '0
)
(
  input wire logic clk,
  input wire logic nrst,
  rshpc_sync_if.sync port_if
);
  // All state of the synchroniser.
  typedef struct packed
  {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] out;
  } rshpc_sync_st_t;
  rshpc_sync_st_t st_reg;
  rshpc_sync_st_t st_next;

  // Shift the stages; the first stage feeds only the second.
  always_comb
  begin
    st_next = st_reg;
    st_next.s1 = port_if.raw;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    for (int i = 0; i < W; i++)
    begin
      // A bit is accepted once the second and third stage agree.
      if (st_reg.s2[i] == st_reg.s3[i])
      begin
        st_next.out[i] = st_reg.s3[i];
      end
      else if (!nrst)
      begin
        // Stages that have not settled yet during reset show the pull level.
        st_next.out[i] = INIT[i];
      end
    end
  end

  // Register the state. The stages keep running through reset, so that straps
  // driven during reset are already filtered and visible when reset is released.
  always_ff @(posedge clk)
  begin
    st_reg <= st_next;
  end

  assign port_if.clean = st_reg.out;
endmodule : rshpc_sync
`default_nettype wire

// ### src/rshpc_top.sv
// Reset sequencer, strap capture and host pin steering of the clock generator.
// Behaviour
// R1: Low reset input resets; outputs realigned afterwards.
// R2: Host holds reset low at least 2 ms.
// R3: Ready bit 7 of address 0x00 after 50 ms.
// R4: Straps pick protocol and master clock rate.
// R5: Host holds pins 0,1,3 at straps 50 ms.
// R6: Host holds pins 4 and 5 low 50 ms.
// R7: Unconnected pins: 5:0 low, 11:6 high.
// R8: SPI takes command, address, data on data-in.
// R9: SPI read data out; I2C address select.
// R10: Chip select active low; I2C address select.
// R11: I2C uses clock pin and bidirectional data.
// R12: Outputs single ended or paired differentially.
// R13: Single-ended outputs choose any single-ended source.
// R14: Differential outputs choose any differential source.
// R15: Test data out on falling edge, else released.
// R16: Test reset low forces Test-Logic-Reset asynchronously.
// R17: High test enable turns on test modes.
// R18: Straps captured once at reset release, held.
`default_nettype none
module rshpc_top
  import rshpc_pkg::*;
#(
  // Wait after release before the ready flag rises, in cycles.
  parameter int unsigned READY_CYCLES = READY_WAIT_CYC
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [GPIO_W-1:0] gpio_in,
  input wire logic [GPIO_W-1:0] gpio_drive_en,
  input wire logic sck_scl_in,
  input wire logic si_sda_in,
  output logic si_sda_out,
  output logic si_sda_oe,
  input wire logic host_serial_out_or_addr_sel_hi_in,
  output logic host_serial_out_or_addr_sel_hi_out,
  output logic host_serial_out_or_addr_sel_hi_oe,
  input wire logic host_select_n_or_addr_sel_lo,
  input wire logic serial_core_miso,
  input wire logic serial_core_sda_low,
  output logic serial_clk,
  output logic serial_data_in,
  output logic spi_select,
  output logic [1:0] i2c_addr_sel,
  output logic proto_spi,
  output logic [1:0] mclk_rate,
  output logic ready,
  output logic realign,
  output logic [7:0] status_word,
  output logic [GPIO_W-1:0] gpio_level,
  input wire logic [PAIR_N-1:0] pair_diff,
  input wire logic [OUT_N*SEL_W-1:0] out_sel,
  input wire logic [(1<<SEL_W)-1:0] se_src,
  input wire logic [(1<<SEL_W)-1:0] diff_src,
  output logic [OUT_N-1:0] out_se,
  output logic [PAIR_N-1:0] out_diff,
  input wire logic tck,
  input wire logic trst_n,
  input wire logic scan_en,
  input wire logic scan_bit,
  output logic tdo_out,
  output logic tdo_oe,
  output logic tap_in_reset,
  input wire logic test_en,
  output logic test_mode
);
  // Counter width large enough for the ready wait.
  localparam int unsigned CNT_W = $clog2(READY_CYCLES + 1);

  // All state of the sequencer.
  typedef struct packed
  {
    rshpc_state_t state;
    logic [CNT_W-1:0] cnt;
    logic proto;
    logic [1:0] rate;
    logic ready;
    logic realign;
  } rshpc_st_t;
  rshpc_st_t st_reg;
  rshpc_st_t st_next;

  // Pin levels resolved with the internal pulls when no one drives them.
  logic [GPIO_W-1:0] gpio_eff;
  // Synchronised pin levels.
  logic [GPIO_W-1:0] gpio_sync;

  // Undriven pins take their pull level.
  always_comb
  begin
    for (int i = 0; i < GPIO_W; i++)
    begin
      gpio_eff[i] = gpio_drive_en[i] ? gpio_in[i] : GPIO_PULL[i]; // R7
    end
  end

  rshpc_sync_if #(.W(GPIO_W)) gpio_if ();
  assign gpio_if.raw = gpio_eff;
  assign gpio_sync = gpio_if.clean;

  // Pins come from outside the clock domain and are filtered here.
  rshpc_sync #(.W(GPIO_W), .INIT(GPIO_PULL)) u_gpio_sync
  (
    .clk(clk),
    .nrst(nrst),
    .port_if(gpio_if)
  );

  // Next state: hold in reset, capture straps at release, then wait.
  always_comb
  begin
    st_next = st_reg;
    st_next.realign = 1'b0;
    case (st_reg.state)
      RSHPC_RESET:
      begin
        // First clocked cycle after release: capture straps once.
        st_next.proto = gpio_sync[PROTO_BIT]; // R4 R18
        st_next.rate = {gpio_sync[RATE_HI_BIT], gpio_sync[RATE_LO_BIT]}; // R4
        st_next.realign = 1'b1; // R1
        st_next.cnt = '0;
        st_next.state = RSHPC_WAIT;
      end
      RSHPC_WAIT:
      begin
        // Count the access wait, then raise the ready flag.
        if (st_reg.cnt == CNT_W'(READY_CYCLES - 1))
        begin
          st_next.ready = 1'b1; // R3
          st_next.state = RSHPC_READY;
        end
        else
        begin
          st_next.cnt = st_reg.cnt + CNT_W'(1);
        end
      end
      RSHPC_READY:
      begin
        // Straps stay held until the next reset.
        st_next.state = RSHPC_READY;
      end
      default:
      begin
        st_next.state = RSHPC_RESET;
      end
    endcase
  end

  // Register the sequencer; a low reset returns everything to rest.
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      st_reg <= '{state: RSHPC_RESET, cnt: '0, proto: 1'b0, rate: 2'b00,
                  ready: 1'b0, realign: 1'b0}; // R1
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign proto_spi = st_reg.proto;
  assign mclk_rate = st_reg.rate;
  assign ready = st_reg.ready;
  assign realign = st_reg.realign;
  assign gpio_level = gpio_sync;
  // Status word at address 0x00 shows the ready flag in bit 7.
  assign status_word = {st_reg.ready, 7'h00}; // R3

  // Host pin steering by the captured protocol.
  always_comb
  begin
    serial_clk = sck_scl_in; // R11
    serial_data_in = si_sda_in; // R8
    if (st_reg.proto == RSHPC_SPI)
    begin
      // SPI: select active low, read data driven out.
      spi_select = ~host_select_n_or_addr_sel_lo; // R10
      i2c_addr_sel = 2'b00;
      host_serial_out_or_addr_sel_hi_out = serial_core_miso; // R9
      host_serial_out_or_addr_sel_hi_oe = ~host_select_n_or_addr_sel_lo; // R9
      si_sda_out = 1'b0;
      si_sda_oe = 1'b0;
    end
    else
    begin
      // I2C: both pins become address selects; data line is open drain.
      spi_select = 1'b0;
      i2c_addr_sel = {host_serial_out_or_addr_sel_hi_in, host_select_n_or_addr_sel_lo}; // R9 R10
      host_serial_out_or_addr_sel_hi_out = 1'b0;
      host_serial_out_or_addr_sel_hi_oe = 1'b0;
      si_sda_out = 1'b0;
      si_sda_oe = serial_core_sda_low; // R11
    end
  end

  // Output routing: each output picks a source; pairs share the even select.
  always_comb
  begin
    for (int i = 0; i < OUT_N; i++)
    begin
      out_se[i] = se_src[out_sel[i*SEL_W +: SEL_W]]; // R13
    end
    for (int p = 0; p < PAIR_N; p++)
    begin
      out_diff[p] = pair_diff[p] ? diff_src[out_sel[2*p*SEL_W +: SEL_W]] : 1'b0; // R12 R14
      if (pair_diff[p])
      begin
        // A paired odd output carries the complement of its partner.
        out_se[2*p+1] = ~diff_src[out_sel[2*p*SEL_W +: SEL_W]]; // R12
        out_se[2*p] = diff_src[out_sel[2*p*SEL_W +: SEL_W]]; // R12
      end
    end
  end

  // Test access: a small tap reset flag and falling edge data out.
  logic tap_rst_reg;
  logic tdo_reg;
  logic tdo_oe_reg;

  // Tap reset is asynchronous to the test clock.
  always_ff @(posedge tck or negedge trst_n)
  begin
    if (!trst_n)
    begin
      tap_rst_reg <= 1'b1; // R16
    end
    else
    begin
      tap_rst_reg <= 1'b0;
    end
  end

  // Data out changes on the falling edge and is released when scan is off.
  always_ff @(negedge tck or negedge trst_n)
  begin
    if (!trst_n)
    begin
      tdo_reg <= 1'b0;
      tdo_oe_reg <= 1'b0; // R15
    end
    else
    begin
      tdo_reg <= scan_bit; // R15
      tdo_oe_reg <= scan_en & ~tap_rst_reg; // R15
    end
  end

  assign tdo_out = tdo_reg;
  assign tdo_oe = tdo_oe_reg;
  assign tap_in_reset = tap_rst_reg;
  assign test_mode = test_en; // R17

  // Ready must rise only in the cycle after the wait state.
  a_ready_wait_done: assert property (@(posedge clk) disable iff (!nrst) // R3
    $rose(ready) |-> $past(st_reg.state) == RSHPC_WAIT)
    else $error("Ready rose outside the wait state.");

  // Straps hold steady once captured.
  a_strap_held_steady: assert property (@(posedge clk) disable iff (!nrst) // R18
    st_reg.state == RSHPC_READY |=> $stable(proto_spi) && $stable(mclk_rate))
    else $error("Straps changed after capture.");

  // Capture takes the synchronised strap pins at the first edge that sees reset high.
  a_strap_capture_value: assert property (@(posedge clk) disable iff (!nrst) // R4
    st_reg.state == RSHPC_RESET && nrst |=> proto_spi == $past(gpio_sync[PROTO_BIT]))
    else $error("Protocol strap not captured.");

  // Realign pulses right after reset release.
  a_realign_after_reset: assert property (@(posedge clk) // R1
    !nrst ##1 nrst |=> realign)
    else $error("No realign after reset.");

  // Ready is low in the cycle after reset.
  a_reset_clears_ready: assert property (@(posedge clk) // R1
    !nrst |=> !ready)
    else $error("Ready survived reset.");

  // In I2C mode the serial out pin is never driven.
  a_i2c_pin_released: assert property (@(posedge clk) disable iff (!nrst) // R9
    !proto_spi |-> !host_serial_out_or_addr_sel_hi_oe)
    else $error("Serial out driven in I2C mode.");

  // In SPI mode the out pin is driven only while selected.
  a_spi_select_low: assert property (@(posedge clk) disable iff (!nrst) // R10
    proto_spi && host_select_n_or_addr_sel_lo |-> !host_serial_out_or_addr_sel_hi_oe)
    else $error("Serial out driven while deselected.");

  // Status bit 7 follows the ready flag.
  a_status_ready_bit: assert property (@(posedge clk) disable iff (!nrst) // R3
    status_word[READY_BIT] == ready && status_word[6:0] == 7'h00)
    else $error("Status word wrong.");

  // Differential pair 0 carries complementary outputs.
  a_pair_complement: assert property (@(posedge clk) disable iff (!nrst) // R12
    pair_diff[0] |-> out_se[1] == ~out_se[0])
    else $error("Pair not complementary.");
endmodule : rshpc_top
`default_nettype wire

// ### tb/rshpc_host_model.sv
// Host model that drives reset and the strap pins of the sequencer.
`default_nettype none
module rshpc_host_model
  import rshpc_pkg::*;
#(
  parameter int unsigned RST_CYC = RST_MIN_CYC,
  parameter int unsigned HOLD_CYC = READY_WAIT_CYC
)
(
  input wire logic clk,
  input wire logic go,
  input wire logic [2:0] strap,
  output logic nrst,
  output logic [GPIO_W-1:0] gpio_in,
  output logic [GPIO_W-1:0] gpio_drive_en
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pins 0, 1 and 3 carry straps; pins 4 and 5 are held low.
  localparam logic [11:0] STRAP_MASK = 12'h03b;
  // Cycles left in the reset and strap hold phases.
  int unsigned cnt = 0;
  // Reset is asserted from time zero.
  initial
  begin
    nrst = 1'b0;
    gpio_in = '0;
    gpio_drive_en = '0;
  end
  // Reset is held, then the straps are held, then the pins are let go.
  always @(posedge clk)
  begin
    if (go)
    begin
      nrst <= 1'b0;
      cnt <= RST_CYC + HOLD_CYC;
      gpio_drive_en <= STRAP_MASK;
      gpio_in <= {8'h00, strap[2], 1'b0, strap[1:0]};
    end
    else if (cnt > 0)
    begin
      cnt <= cnt - 1;
      if (cnt == HOLD_CYC + 1)
        nrst <= 1'b1;
      if (cnt == 1)
      begin
        gpio_drive_en <= '0;
        gpio_in <= ~gpio_in;
      end
    end
  end
endmodule // rshpc_host_model
`default_nettype wire

// ### tb/reset_strap_host_pin_config_tb.sv
// Self-checking bench of the reset sequencer, strap capture and pin steering.
`default_nettype none
`define CMP(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fails++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module reset_strap_host_pin_config_tb
  import rshpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // Shortened ready wait.
  localparam int unsigned RC = 10;
  typedef struct {int id; logic [15:0] e;} rshpc_note_t;
  rshpc_note_t notes[$];
  rshpc_note_t n;
  int fails = 0, n_compared = 0, cyc = 0;
  logic clk, nrst, go = 0, sck = 0, sda_in = 0, hi_in = 0, sel_n = 1, miso = 0;
  logic sda_low = 0, tck = 0, trst_n = 0, scan_en = 0, scan_bit = 0, test_en = 0;
  logic [2:0] strap = '0;
  logic [5:0] r;
  logic [3:0] pair_diff = '0, se_src = '0, diff_src = '0, a, b, d, out_diff;
  logic [15:0] out_sel = '0, rs;
  logic [7:0] e, out_se, status_word;
  logic [11:0] gpio_in, gpio_drive_en, gpio_level;
  logic si_sda_out, si_sda_oe, hi_out, hi_oe, serial_clk, serial_data_in, spi_select;
  logic proto_spi, ready, realign, tdo_out, tdo_oe, tap_in_reset, test_mode;
  logic [1:0] i2c_addr_sel, mclk_rate;
  string nm [20] = '{"ready", "realign", "proto", "rate", "status", "gpio_level",
    "serial_clk", "serial_data_in", "spi_select", "i2c_addr_sel", "sda_oe", "sda_out",
    "so_oe", "so_out", "out_se", "out_diff", "tdo_oe", "tap_in_reset", "test_mode",
    "tdo_out"};
  // Clock of 20 ns period.
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  rshpc_host_model #(.RST_CYC(5), .HOLD_CYC(RC)) i_host (.clk(clk), .go(go),
    .strap(strap), .nrst(nrst), .gpio_in(gpio_in), .gpio_drive_en(gpio_drive_en));
  rshpc_top #(.READY_CYCLES(RC)) i_dut (.clk(clk), .nrst(nrst), .gpio_in(gpio_in),
    .gpio_drive_en(gpio_drive_en), .sck_scl_in(sck), .si_sda_in(sda_in),
    .si_sda_out(si_sda_out), .si_sda_oe(si_sda_oe),
    .host_serial_out_or_addr_sel_hi_in(hi_in), .host_serial_out_or_addr_sel_hi_out(hi_out),
    .host_serial_out_or_addr_sel_hi_oe(hi_oe), .host_select_n_or_addr_sel_lo(sel_n),
    .serial_core_miso(miso), .serial_core_sda_low(sda_low), .serial_clk(serial_clk),
    .serial_data_in(serial_data_in), .spi_select(spi_select), .i2c_addr_sel(i2c_addr_sel),
    .proto_spi(proto_spi), .mclk_rate(mclk_rate), .ready(ready), .realign(realign),
    .status_word(status_word), .gpio_level(gpio_level), .pair_diff(pair_diff),
    .out_sel(out_sel), .se_src(se_src), .diff_src(diff_src), .out_se(out_se),
    .out_diff(out_diff), .tck(tck), .trst_n(trst_n), .scan_en(scan_en),
    .scan_bit(scan_bit), .tdo_out(tdo_out), .tdo_oe(tdo_oe),
    .tap_in_reset(tap_in_reset), .test_en(test_en), .test_mode(test_mode));
  // Picks the output named by a note.
  function automatic logic [15:0] obs(int id);
    case (id)
      0: return 16'(ready);
      1: return 16'(realign);
      2: return 16'(proto_spi);
      3: return 16'(mclk_rate);
      4: return 16'(status_word);
      5: return 16'(gpio_level);
      6: return 16'(serial_clk);
      7: return 16'(serial_data_in);
      8: return 16'(spi_select);
      9: return 16'(i2c_addr_sel);
      10: return 16'(si_sda_oe);
      11: return 16'(si_sda_out);
      12: return 16'(hi_oe);
      13: return 16'(hi_out);
      14: return 16'(out_se);
      15: return 16'(out_diff);
      16: return 16'(tdo_oe);
      17: return 16'(tap_in_reset);
      18: return 16'(test_mode);
      default: return 16'(tdo_out);
    endcase
  endfunction
  // Notes one expected output value.
  task automatic ex(int id, logic [15:0] v);
    notes.push_back('{id, v});
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Outputs have settled by the falling edge; every pending note is checked there.
  always @(negedge clk)
    while (notes.size() > 0)
    begin
      n = notes.pop_front();
      `CMP(nm[n.id], n.e, obs(n.id))
    end
  // Test clock at half the system rate, scan data random; a hang ends the run.
  always @(posedge clk)
  begin
    tck <= ~tck;
    // Scan data moves only as the test clock rises, so it stands still at the fall.
    if (!tck)
      scan_bit <= 1'($urandom);
    cyc++;
    if (cyc == 2000)
    begin
      fails++;
      complete_run();
    end
  end
  // Main sequence.
  initial
  begin
    void'($urandom(13));
    for (int k = 0; k < 8; k++)
    begin
      @(posedge clk);
      strap <= 3'(k);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      // The host model lowers reset at this edge; the design applies it at the next.
      @(posedge clk);
      ex(0, 16'h0000);
      ex(5, 16'(GPIO_PULL));
      // Reset stays low for five edges; this is the first edge that sees it high.
      repeat (5)
        @(posedge clk);
      ex(0, 16'h0000);
      ex(1, 16'h0001);
      ex(5, 16'(GPIO_PULL) | 16'((k & 4) << 1) | 16'(k & 3));
      for (int c = 1; c <= RC + 6; c++)
      begin
        ex(2, 16'(k >> 2));
        ex(3, 16'(k & 3));
        @(posedge clk);
        ex(0, 16'(c >= RC));
        ex(1, 16'h0000);
      end
      ex(4, 16'h0080);
      ex(5, 16'(GPIO_PULL));
      repeat (4)
      begin
        @(posedge clk);
        r = 6'($urandom);
        {sck, sda_in, hi_in, sel_n, miso, sda_low} <= r;
        ex(6, 16'(r[5]));
        ex(7, 16'(r[4]));
        if (k >= 4)
        begin
          ex(8, 16'(!r[2]));
          ex(12, 16'(!r[2]));
          if (!r[2])
            ex(13, 16'(r[1]));
        end
        else
        begin
          ex(9, 16'(r[3:2]));
          ex(10, 16'(r[0]));
          ex(11, 16'h0000);
          ex(12, 16'h0000);
        end
      end
    end
    repeat (8)
    begin
      @(posedge clk);
      rs = 16'($urandom);
      a = 4'($urandom);
      b = 4'($urandom);
      out_sel <= rs;
      se_src <= a;
      diff_src <= b;
      pair_diff <= 4'h0;
      for (int i = 0; i < 8; i++)
        e[i] = a[rs[2*i +: 2]];
      ex(14, 16'(e));
      @(posedge clk);
      pair_diff <= 4'hf;
      for (int p = 0; p < 4; p++)
        d[p] = b[rs[4*p +: 2]];
      ex(15, 16'(d));
      // Paired outputs carry the pair's clock and its complement.
      for (int p = 0; p < 4; p++)
      begin
        e[2*p] = d[p];
        e[2*p+1] = ~d[p];
      end
      ex(14, 16'(e));
    end
    @(posedge clk);
    ex(17, 16'h0001);
    ex(16, 16'h0000);
    ex(18, 16'h0000);
    @(posedge clk);
    trst_n <= 1'b1;
    scan_en <= 1'b1;
    test_en <= 1'b1;
    ex(18, 16'h0001);
    repeat (8)
      @(posedge clk);
    ex(17, 16'h0000);
    ex(16, 16'h0001);
    ex(18, 16'h0001);
    // At each falling test clock edge the data out takes the steady scan bit.
    repeat (4)
    begin
      @(posedge clk);
      if (tck)
        ex(19, 16'(scan_bit));
    end
    scan_en <= 1'b0;
    repeat (6)
      @(posedge clk);
    ex(16, 16'h0000);
    @(posedge clk);
    scan_en <= 1'b1;
    repeat (6)
      @(posedge clk);
    trst_n <= 1'b0;
    test_en <= 1'b0;
    ex(17, 16'h0001);
    ex(16, 16'h0000);
    ex(18, 16'h0000);
    repeat (2)
      @(negedge clk);
    complete_run();
  end
endmodule // reset_strap_host_pin_config_tb
`default_nettype wire
